//--- inc/dbd_pkg.sv
// Package: register map, field positions and pipeline states of the disk buffer DMA set-up block
package dbd_pkg;

    // =========================================================
    // Register offsets on the 8-bit multiplexed port
    localparam logic [7:0] OFF_HOST_CAP_HIGH  = 8'hA6;
    localparam logic [7:0] OFF_HOST_CAP_LOW   = 8'hA8;
    localparam logic [7:0] OFF_ACCESS_CTRL    = 8'hAA;
    localparam logic [7:0] OFF_SEGMENT_SELECT = 8'hAC;
    localparam logic [7:0] OFF_REL_ADDR_HIGH  = 8'hAE;
    localparam logic [7:0] OFF_REL_ADDR_MID   = 8'hB0;
    localparam logic [7:0] OFF_REL_ADDR_LOW   = 8'hB2;
    localparam logic [7:0] OFF_BLOCK_COUNT    = 8'hB4;
    localparam logic [7:0] OFF_MASK_HIGH      = 8'hB6;
    localparam logic [7:0] OFF_MASK_LOW       = 8'hB8;

    // =========================================================
    // Access control field positions
    localparam int BIT_BOUNDARY_ECC_HOLD = 7;
    localparam int BIT_SKIP_MASK_ENABLE  = 6;
    localparam int BIT_NO_DATA_TRANSFER  = 4;
    localparam int BIT_DISK_DIRECTION    = 3;
    localparam int BIT_WRITE_SAME_ENABLE = 1;
    localparam int BIT_DISK_COUNT_ENABLE = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hDB;
    localparam int BIT_PENDING_CHANGE    = 7;

    // =========================================================
    // Widths and reset values
    localparam int ADDR_W  = 23;
    localparam int SEG_W   = 5;
    localparam int COUNT_W = 15;
    localparam int MASK_W  = 16;
    localparam int BLK_W   = 8;
    localparam int SYNC_W  = 12;
    localparam logic [7:0]         RST_BYTE  = 8'h00;
    localparam logic [ADDR_W-1:0]  RST_ADDR  = 23'h00_0000;
    localparam logic [COUNT_W-1:0] RST_COUNT = 15'h0000;
    localparam logic [MASK_W-1:0]  RST_MASK  = 16'h0000;
    localparam logic [SEG_W-1:0]   RST_SEG   = 5'h00;
    localparam logic [BLK_W-1:0]   ONE_BLOCK = 8'h01;
    localparam logic [BLK_W-1:0]   TWO_BLOCK = 8'h02;

    // =========================================================
    // Pipeline states
    typedef enum logic [1:0] {
        PIPE_IDLE,
        PIPE_BUSY,
        PIPE_VERY_BUSY
    } dbd_pipe_t;

endpackage : dbd_pkg

//--- hdl/dbd_sync.sv
// Two-flop synchroniser for the processor port pins
`timescale 1ns/1ps
module dbd_sync #(
    parameter int W = 12
) (
    input  wire logic         ref_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] safe;
    } dbd_sync_t;

    dbd_sync_t st_r;
    dbd_sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (ce_i) begin
            st_nxt.meta = d_i;
            st_nxt.safe = st_r.meta;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.safe;

endmodule : dbd_sync

//--- hdl/dbd_setup.sv
// Disk buffer DMA set-up registers, pipeline loads and common buffer counter
//
// Summary of operation
// - Host capture pair reads count and flag
// - Writing high capture byte loads counter
// - Boundary ECC error suppresses next pipeline transfer
// - Skip mask gates blocks; count limited 16
// - No-data bit blocks all buffer transfers
// - Direction bit: set writes buffer
// - Write-same mode uses transfer mask
// - Counter increments per transferred disk block
// - Five-bit segment select picks segment
// - Absolute address is segment times size plus offset
// - Unreloaded segment and count are reused
// - Unreloaded address continues from last address
// - Block count reads return captured value
// - Sixteen-bit mask held per pipeline load
// - Pending-change flag set, cleared, soft reset
// - Start translates load and raises pipeline
`timescale 1ns/1ps
module dbd_setup (
    input  wire logic                        ref_clk_i,
    input  wire logic                        resetn_i,
    input  wire logic                        ce_i,
    // Multiplexed processor port pins
    input  wire logic                        ale_i,
    input  wire logic                        cs_n_i,
    input  wire logic                        wr_n_i,
    input  wire logic                        rd_n_i,
    input  wire logic [7:0]                  ad_i,
    output logic      [7:0]                  ad_o,
    output logic                             ad_oe_o,
    // Same-clock control from the rest of the disk manager
    input  wire logic                        disk_start_command_i,
    input  wire logic                        disk_stop_i,
    input  wire logic                        soft_reset_bit_i,
    input  wire logic                        host_capture_i,
    input  wire logic                        disk_capture_request_i,
    input  wire logic [dbd_pkg::ADDR_W-1:0]  segment_size_i,
    input  wire logic                        block_done_i,
    input  wire logic                        addr_step_i,
    input  wire logic                        ecc_pending_i,
    input  wire logic                        ecc_done_ok_i,
    input  wire logic                        ecc_uncorrectable_i,
    // Pipeline outputs
    output logic      [dbd_pkg::ADDR_W-1:0]  abs_addr_o,
    output logic      [dbd_pkg::BLK_W-1:0]   blocks_left_o,
    output logic      [dbd_pkg::MASK_W-1:0]  transfer_mask_o,
    output logic                             busy_o,
    output logic                             very_busy_o,
    output logic                             block_xfer_en_o,
    output logic                             disk_direction_o,
    output logic                             write_same_o,
    output logic                             transfer_held_o,
    output logic      [dbd_pkg::COUNT_W-1:0] buffer_count_o,
    output logic                             pending_change_flag_o
);

    // =========================================================
    // State
    typedef struct packed {
        logic [7:0]                  bus_addr;
        logic                        wr_n_q;
        logic [7:0]                  ctrl;
        logic [dbd_pkg::SEG_W-1:0]   seg;
        logic [dbd_pkg::ADDR_W-1:0]  rel;
        logic                        rel_new;
        logic [dbd_pkg::BLK_W-1:0]   bcnt;
        logic [dbd_pkg::MASK_W-1:0]  mask;
        logic [dbd_pkg::COUNT_W-1:0] host_captured_count;
        logic [dbd_pkg::COUNT_W-1:0] buf_cnt;
        logic                        pending_change_flag;
        logic [dbd_pkg::BLK_W-1:0]   disk_capture_request;
        dbd_pkg::dbd_pipe_t          pipe;
        logic [dbd_pkg::ADDR_W-1:0]  act_addr;
        logic [dbd_pkg::BLK_W-1:0]   act_left;
        logic [dbd_pkg::BLK_W-1:0]   act_idx;
        logic [dbd_pkg::MASK_W-1:0]  act_mask;
        logic [dbd_pkg::ADDR_W-1:0]  q_addr;
        logic [dbd_pkg::BLK_W-1:0]   q_left;
        logic [dbd_pkg::MASK_W-1:0]  q_mask;
        logic                        suppress;
        logic                        held;
        logic                        xfer_en;
        logic [7:0]                  rd_data;
        logic                        rd_oe;
    } dbd_state_t;

    dbd_state_t st_r;
    dbd_state_t st_nxt;

    logic [dbd_pkg::SYNC_W-1:0] pins_s;
    logic                       ale_s;
    logic                       cs_s;
    logic                       wr_n_s;
    logic                       rd_n_s;
    logic [7:0]                 ad_s;

    // Pins come from the processor's clock, so every one is synchronised
    dbd_sync #(
        .W (dbd_pkg::SYNC_W)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .d_i       ({ale_i, ~cs_n_i, wr_n_i, rd_n_i, ad_i}),
        .q_o       (pins_s)
    );

    assign ale_s  = pins_s[11];
    assign cs_s   = pins_s[10];
    assign wr_n_s = pins_s[9];
    assign rd_n_s = pins_s[8];
    assign ad_s   = pins_s[7:0];

    // =========================================================
    // Next-state logic
    always_comb begin
        logic                        wr_stb;
        logic                        load_done;
        logic                        blk_moved;
        logic                        skip_on;
        logic                        xfer_now;
        logic [dbd_pkg::ADDR_W-1:0]  start_addr;
        logic [dbd_pkg::ADDR_W-1:0]  seg_base;
        logic [2*dbd_pkg::ADDR_W-1:0] product;

        wr_stb     = 1'b0;
        load_done  = 1'b0;
        blk_moved  = 1'b0;
        skip_on    = 1'b0;
        xfer_now   = 1'b0;
        start_addr = '0;
        seg_base   = '0;
        product    = '0;
        st_nxt     = st_r;

        if (ce_i) begin
            st_nxt.wr_n_q = wr_n_s;
            if (ale_s) begin
                st_nxt.bus_addr = ad_s;
            end
            // Data is taken at the trailing edge of the write strobe, when it is surely settled
            wr_stb = cs_s && wr_n_s && !st_r.wr_n_q;

            // ==================== Register writes
            if (wr_stb) begin
                unique case (st_r.bus_addr)
                    dbd_pkg::OFF_HOST_CAP_HIGH: begin
                        st_nxt.host_captured_count[14:8] = ad_s[6:0];
                        st_nxt.buf_cnt = {ad_s[6:0], st_r.host_captured_count[7:0]};
                    end
                    dbd_pkg::OFF_ACCESS_CTRL:    st_nxt.ctrl = ad_s & dbd_pkg::CTRL_WRITE_MASK;
                    dbd_pkg::OFF_SEGMENT_SELECT: st_nxt.seg = ad_s[dbd_pkg::SEG_W-1:0];
                    dbd_pkg::OFF_REL_ADDR_HIGH: begin
                        st_nxt.rel[22:16] = ad_s[6:0];
                        st_nxt.rel_new    = 1'b1;
                    end
                    dbd_pkg::OFF_REL_ADDR_MID: begin
                        st_nxt.rel[15:8] = ad_s;
                        st_nxt.rel_new   = 1'b1;
                    end
                    dbd_pkg::OFF_REL_ADDR_LOW: begin
                        st_nxt.rel[7:0] = ad_s;
                        st_nxt.rel_new  = 1'b1;
                    end
                    dbd_pkg::OFF_BLOCK_COUNT: st_nxt.bcnt = ad_s;
                    dbd_pkg::OFF_MASK_HIGH:   st_nxt.mask[15:8] = ad_s;
                    dbd_pkg::OFF_MASK_LOW:    st_nxt.mask[7:0] = ad_s;
                    default: ;
                endcase
            end

            // ==================== Register reads
            st_nxt.rd_oe   = cs_s && !rd_n_s;
            st_nxt.rd_data = dbd_pkg::RST_BYTE;
            unique case (st_r.bus_addr)
                dbd_pkg::OFF_HOST_CAP_HIGH:
                    st_nxt.rd_data = {st_r.pending_change_flag, st_r.host_captured_count[14:8]};
                dbd_pkg::OFF_HOST_CAP_LOW:   st_nxt.rd_data = st_r.host_captured_count[7:0];
                dbd_pkg::OFF_ACCESS_CTRL:    st_nxt.rd_data = st_r.ctrl;
                dbd_pkg::OFF_SEGMENT_SELECT: st_nxt.rd_data = {3'b000, st_r.seg};
                dbd_pkg::OFF_REL_ADDR_HIGH:  st_nxt.rd_data = {1'b0, st_r.rel[22:16]};
                dbd_pkg::OFF_REL_ADDR_MID:   st_nxt.rd_data = st_r.rel[15:8];
                dbd_pkg::OFF_REL_ADDR_LOW:   st_nxt.rd_data = st_r.rel[7:0];
                dbd_pkg::OFF_BLOCK_COUNT:    st_nxt.rd_data = st_r.disk_capture_request;
                dbd_pkg::OFF_MASK_HIGH:      st_nxt.rd_data = st_r.mask[15:8];
                dbd_pkg::OFF_MASK_LOW:       st_nxt.rd_data = st_r.mask[7:0];
                default:                     st_nxt.rd_data = dbd_pkg::RST_BYTE;
            endcase

            // ==================== Captures
            if (host_capture_i) begin
                st_nxt.host_captured_count = st_r.buf_cnt;
            end
            if (disk_capture_request_i) begin
                st_nxt.disk_capture_request = st_r.act_left;
            end

            // ==================== Block movement
            skip_on  = st_r.ctrl[dbd_pkg::BIT_SKIP_MASK_ENABLE];
            // With skip mask enabled, block n of the load is gated by mask bit n; beyond bit 15 nothing moves
            xfer_now = (st_r.pipe != dbd_pkg::PIPE_IDLE)
                       && !st_r.ctrl[dbd_pkg::BIT_NO_DATA_TRANSFER]
                       && !st_r.suppress
                       && (!skip_on || ((st_r.act_idx < 8'h10) && st_r.act_mask[st_r.act_idx[3:0]]));
            st_nxt.xfer_en = xfer_now;

            if (addr_step_i && xfer_now) begin
                st_nxt.act_addr = st_r.act_addr + 23'h00_0001;
            end

            if (block_done_i && (st_r.pipe != dbd_pkg::PIPE_IDLE)) begin
                blk_moved       = xfer_now;
                st_nxt.act_left = st_r.act_left - dbd_pkg::ONE_BLOCK;
                st_nxt.act_idx  = st_r.act_idx + dbd_pkg::ONE_BLOCK;
                load_done       = (st_r.act_left <= dbd_pkg::ONE_BLOCK);
            end
            if (blk_moved && st_r.ctrl[dbd_pkg::BIT_DISK_COUNT_ENABLE]) begin
                st_nxt.buf_cnt = st_nxt.buf_cnt + 15'h0001;
            end

            // Uncorrectable error on the second-to-last sector of this load
            if (ecc_uncorrectable_i && st_r.ctrl[dbd_pkg::BIT_BOUNDARY_ECC_HOLD]
                && (st_r.pipe != dbd_pkg::PIPE_IDLE) && (st_r.act_left == dbd_pkg::TWO_BLOCK)) begin
                st_nxt.suppress = 1'b1;
            end

            // ==================== Load translation
            product  = {{(dbd_pkg::ADDR_W - dbd_pkg::SEG_W){1'b0}}, st_r.seg} * segment_size_i;
            seg_base = product[dbd_pkg::ADDR_W-1:0];
            // A fresh offset is translated; otherwise the load carries on where the last stopped
            start_addr = st_r.rel_new ? (seg_base + st_r.rel) : st_r.act_addr;

            // Cleared before sequencing so that a change in the same cycle wins
            if (ecc_done_ok_i) begin
                st_nxt.pending_change_flag = 1'b0;
            end

            // ==================== Pipeline sequencing
            unique case (st_r.pipe)
                dbd_pkg::PIPE_IDLE: begin
                    if (disk_start_command_i) begin
                        st_nxt.pipe     = dbd_pkg::PIPE_BUSY;
                        st_nxt.act_addr = start_addr;
                        st_nxt.act_left = st_r.bcnt;
                        st_nxt.act_mask = st_r.mask;
                        st_nxt.act_idx  = '0;
                        st_nxt.rel_new  = 1'b0;
                        st_nxt.held     = 1'b0;
                        st_nxt.suppress = 1'b0;
                    end
                end
                dbd_pkg::PIPE_BUSY: begin
                    if (load_done) begin
                        st_nxt.pipe     = dbd_pkg::PIPE_IDLE;
                        st_nxt.held     = st_r.suppress;
                        st_nxt.suppress = 1'b0;
                    end else if (disk_start_command_i) begin
                        st_nxt.pipe    = dbd_pkg::PIPE_VERY_BUSY;
                        st_nxt.q_addr  = start_addr;
                        st_nxt.q_left  = st_r.bcnt;
                        st_nxt.q_mask  = st_r.mask;
                        st_nxt.rel_new = 1'b0;
                    end
                end
                dbd_pkg::PIPE_VERY_BUSY: begin
                    // A third start has no slot and is dropped
                    if (load_done) begin
                        if (st_r.suppress) begin
                            st_nxt.pipe = dbd_pkg::PIPE_IDLE;
                            st_nxt.held = 1'b1;
                        end else begin
                            st_nxt.pipe     = dbd_pkg::PIPE_BUSY;
                            st_nxt.act_addr = st_r.q_addr;
                            st_nxt.act_left = st_r.q_left;
                            st_nxt.act_mask = st_r.q_mask;
                            st_nxt.act_idx  = '0;
                            if (ecc_pending_i) begin
                                st_nxt.pending_change_flag = 1'b1;
                            end
                        end
                        st_nxt.suppress = 1'b0;
                    end
                end
                default: st_nxt.pipe = dbd_pkg::PIPE_IDLE;
            endcase

            if (disk_stop_i || soft_reset_bit_i) begin
                st_nxt.pipe     = dbd_pkg::PIPE_IDLE;
                st_nxt.suppress = 1'b0;
            end
            if (soft_reset_bit_i) begin
                st_nxt.pending_change_flag = 1'b0;
                st_nxt.held = 1'b0;
            end
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r      <= '0;
            st_r.pipe <= dbd_pkg::PIPE_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // Outputs, all from state flops; busy_o and very_busy_o are decoded from pipe
    assign ad_o                  = st_r.rd_data;
    assign ad_oe_o               = st_r.rd_oe;
    assign abs_addr_o            = st_r.act_addr;
    assign blocks_left_o         = st_r.act_left;
    assign transfer_mask_o       = st_r.act_mask;
    assign busy_o                = (st_r.pipe != dbd_pkg::PIPE_IDLE);
    assign very_busy_o           = (st_r.pipe == dbd_pkg::PIPE_VERY_BUSY);
    assign block_xfer_en_o       = st_r.xfer_en;
    assign disk_direction_o      = st_r.ctrl[dbd_pkg::BIT_DISK_DIRECTION];
    assign write_same_o          = st_r.ctrl[dbd_pkg::BIT_WRITE_SAME_ENABLE];
    assign transfer_held_o       = st_r.held;
    assign buffer_count_o        = st_r.buf_cnt;
    assign pending_change_flag_o = st_r.pending_change_flag;

endmodule : dbd_setup

//--- verif/dbd_setup_assertions.sv
// Checker: port-level assertions for the disk buffer DMA set-up block
`timescale 1ns/1ps
module dbd_setup_assertions (
    input wire logic       ref_clk_i,
    input wire logic       resetn_i,
    input wire logic       ce_i,
    input wire logic       cs_n_i,
    input wire logic       rd_n_i,
    input wire logic       disk_start_command_i,
    input wire logic       disk_stop_i,
    input wire logic       soft_reset_bit_i,
    input wire logic       block_done_i,
    input wire logic       ecc_pending_i,
    input wire logic       ecc_done_ok_i,
    input wire logic [7:0] blocks_left_o,
    input wire logic       busy_o,
    input wire logic       very_busy_o,
    input wire logic       ad_oe_o,
    input wire logic       pending_change_flag_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic go;
    // Stop and soft reset win over every other pipeline request
    assign go = ce_i && !disk_stop_i && !soft_reset_bit_i;
    vb_has_busy_a: assert property (very_busy_o |-> busy_o)
        else $error("very busy seen without busy");
    idle_start_a: assert property (go && !busy_o && disk_start_command_i |=> busy_o && !very_busy_o)
        else $error("start from idle did not give busy");
    busy_start_a: assert property (go && busy_o && !very_busy_o && disk_start_command_i && !block_done_i
        |=> very_busy_o)
        else $error("start while busy did not give very busy");
    stop_idle_a: assert property (ce_i && (disk_stop_i || soft_reset_bit_i) |=> !busy_o && !very_busy_o)
        else $error("pipeline not idle after stop");
    soft_reset_bit_flag_a: assert property (ce_i && soft_reset_bit_i |=> !pending_change_flag_o)
        else $error("flag survived soft reset");
    flag_cause_a: assert property ($rose(pending_change_flag_o) |-> $past(very_busy_o) && $past(ecc_pending_i))
        else $error("flag rose without cause");
    flag_clear_a: assert property (go && pending_change_flag_o && ecc_done_ok_i && !very_busy_o
        |=> !pending_change_flag_o)
        else $error("flag not cleared by correction");
    last_block_a: assert property (go && busy_o && !very_busy_o && block_done_i && blocks_left_o == 8'h01
        && !disk_start_command_i |=> !busy_o)
        else $error("last block did not end load");
    blk_decr_a: assert property (go && busy_o && block_done_i && blocks_left_o > 8'h01
        |=> blocks_left_o == $past(blocks_left_o) - 8'h01)
        else $error("block count did not step down");
    read_drive_a: assert property ((ce_i && !cs_n_i && !rd_n_i) [*4] |-> ad_oe_o)
        else $error("read data not driven");
    read_release_a: assert property ((ce_i && rd_n_i) [*4] |-> !ad_oe_o)
        else $error("data bus not released");
    cover property (very_busy_o);
    cover property ($rose(pending_change_flag_o));
    cover property ($fell(ad_oe_o));
endmodule : dbd_setup_assertions

bind dbd_setup dbd_setup_assertions chk_u (.*);

//--- verif/dbd_cpu_model.sv
// Partner model: processor cycles on the multiplexed register port
`timescale 1ns/1ps
module dbd_cpu_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_ad_i,
    output logic            ale_o,
    output logic            cs_n_o,
    output logic            wr_n_o,
    output logic            rd_n_o,
    output logic [7:0]      ad_o
);
    initial {ale_o, cs_n_o, wr_n_o, rd_n_o, ad_o} = {4'h7, 8'h5A};
    // Read and write strobes held four cycles, ALE three, so the pin synchroniser always sees them
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        ale_o = 1'b1;
        ad_o = a;
        repeat (3) @(negedge clk_i);
        ale_o = 1'b0;
        ad_o = wr ? d : ~a;
        wr_n_o = !wr;
        rd_n_o = wr;
        repeat (4) @(negedge clk_i);
        q = pin_ad_i;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        // Released bus shows the inverse, not the last value
        ad_o = ~ad_o;
    endtask : xfer
endmodule : dbd_cpu_model

//--- verif/dbd_setup_tb.sv
// Testbench: register port and pipeline scenarios for the disk buffer DMA set-up block
`timescale 1ns/1ps
module dbd_setup_tb;
    logic ref_clk_i, resetn_i, ce_i, ale_i, cs_n_i, wr_n_i, rd_n_i, ad_oe_o;
    logic disk_start_command_i, disk_stop_i, soft_reset_bit_i, host_capture_i, disk_capture_request_i;
    logic block_done_i, addr_step_i, ecc_pending_i, ecc_done_ok_i, ecc_uncorrectable_i;
    logic busy_o, very_busy_o, block_xfer_en_o, disk_direction_o, write_same_o;
    logic transfer_held_o, pending_change_flag_o;
    logic [7:0]                  ad_i, ad_o, cpu_ad, blocks_left_o, q;
    logic [dbd_pkg::ADDR_W-1:0]  segment_size_i, abs_addr_o;
    logic [dbd_pkg::MASK_W-1:0]  transfer_mask_o;
    logic [dbd_pkg::COUNT_W-1:0] buffer_count_o;
    int                          err_count, n_compared, cyc;
    assign ad_i = ad_oe_o ? ad_o : cpu_ad;
    dbd_setup dut_u (.*);
    dbd_cpu_model cpu_u (.clk_i(ref_clk_i), .pin_ad_i(ad_i), .ale_o(ale_i), .cs_n_o(cs_n_i),
        .wr_n_o(wr_n_i), .rd_n_o(rd_n_i), .ad_o(cpu_ad));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // ==========================================
    // Helpers
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu_u.xfer(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cpu_u.xfer(a, 1'b0, 8'h00, q);
        chk(32'(q), 32'(e));
    endtask : rd
    task automatic pulse(ref logic s);
        @(negedge ref_clk_i);
        s = 1'b1;
        @(negedge ref_clk_i);
        s = 1'b0;
    endtask : pulse
    task automatic blocks(input int n, input logic [15:0] en);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk_i);
            chk(32'(block_xfer_en_o), 32'(en[i]));
            pulse(block_done_i);
        end
    endtask : blocks
    // Control is rewritten only while the pipeline is idle
    task automatic load(input logic [7:0] ctl, sg, cnt, input logic [22:0] rel, input logic [15:0] m);
        wr(8'hAA, ctl);
        wr(8'hAC, sg);
        wr(8'hAE, {1'b0, rel[22:16]});
        wr(8'hB0, rel[15:8]);
        wr(8'hB2, rel[7:0]);
        wr(8'hB4, cnt);
        wr(8'hB6, m[15:8]);
        wr(8'hB8, m[7:0]);
        pulse(disk_start_command_i);
    endtask : load
    // ==========================================
    // Scenarios
    task automatic t_regs;
        logic [7:0] off [7] = '{8'hAA, 8'hAC, 8'hAE, 8'hB0, 8'hB2, 8'hB6, 8'hB8};
        logic [7:0] dat [7] = '{8'hFF, 8'h13, 8'h45, 8'hA5, 8'h5A, 8'hC3, 8'h3C};
        logic [7:0] exp [7] = '{8'hDB, 8'h13, 8'h45, 8'hA5, 8'h5A, 8'hC3, 8'h3C};
        for (int i = 0; i < 7; i++) wr(off[i], dat[i]);
        for (int i = 0; i < 7; i++) rd(off[i], exp[i]);
        wr(8'hA8, 8'h77);
        rd(8'hA8, 8'h00);
        wr(8'hB4, 8'h09);
        rd(8'hB4, 8'h00);
        rd(8'h90, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_addr;
        load(8'h0A, 8'h03, 8'h04, 23'h00_0123, 16'hA5C3);
        chk(32'(abs_addr_o), 32'h3123);
        chk(32'(blocks_left_o), 32'h4);
        chk(32'(transfer_mask_o), 32'hA5C3);
        chk(32'(disk_direction_o), 32'h1);
        chk(32'(write_same_o), 32'h1);
        pulse(addr_step_i);
        pulse(addr_step_i);
        chk(32'(abs_addr_o), 32'h3125);
        blocks(4, 16'hFFFF);
        chk(32'(busy_o), 32'h0);
        pulse(disk_start_command_i);
        chk(32'(abs_addr_o), 32'h3125);
        chk(32'(blocks_left_o), 32'h4);
        blocks(4, 16'hFFFF);
        wr(8'hB2, 8'h10);
        pulse(disk_start_command_i);
        chk(32'(abs_addr_o), 32'h3110);
        blocks(4, 16'hFFFF);
        segment_size_i = 23'h00_0200;
        wr(8'hAC, 8'h1F);
        wr(8'hB2, 8'h10);
        pulse(disk_start_command_i);
        chk(32'(abs_addr_o), 32'h3F10);
        blocks(4, 16'hFFFF);
        $display("test addr done");
    endtask : t_addr
    task automatic t_pipe;
        load(8'h00, 8'h00, 8'h02, 23'h00_0000, 16'h0000);
        pulse(disk_start_command_i);
        chk(32'(very_busy_o), 32'h1);
        ecc_pending_i = 1'b1;
        pulse(disk_capture_request_i);
        blocks(2, 16'hFFFF);
        chk(32'({busy_o, very_busy_o, pending_change_flag_o}), 32'h5);
        ecc_pending_i = 1'b0;
        rd(8'hB4, 8'h02);
        pulse(host_capture_i);
        rd(8'hA6, 8'h80);
        pulse(ecc_done_ok_i);
        chk(32'(pending_change_flag_o), 32'h0);
        pulse(soft_reset_bit_i);
        chk(32'(busy_o), 32'h0);
        $display("test pipe done");
    endtask : t_pipe
    task automatic t_count;
        load(8'h01, 8'h00, 8'h03, 23'h00_0000, 16'h0000);
        blocks(3, 16'hFFFF);
        chk(32'(buffer_count_o), 32'h3);
        load(8'h11, 8'h00, 8'h03, 23'h00_0000, 16'h0000);
        blocks(3, 16'h0000);
        chk(32'(buffer_count_o), 32'h3);
        load(8'h41, 8'h00, 8'h03, 23'h00_0000, 16'h0005);
        blocks(3, 16'h0005);
        chk(32'(buffer_count_o), 32'h5);
        pulse(host_capture_i);
        rd(8'hA6, 8'h00);
        rd(8'hA8, 8'h05);
        wr(8'hA6, 8'h12);
        chk(32'(buffer_count_o), 32'h1205);
        load(8'h81, 8'h00, 8'h03, 23'h00_0000, 16'h0000);
        pulse(disk_start_command_i);
        blocks(1, 16'hFFFF);
        pulse(ecc_uncorrectable_i);
        blocks(2, 16'h0000);
        chk(32'({busy_o, transfer_held_o}), 32'h1);
        chk(32'(buffer_count_o), 32'h1206);
        $display("test count done");
    endtask : t_count
    // ==========================================
    // Main sequence and hang guard
    initial begin
        {resetn_i, disk_start_command_i, disk_stop_i, soft_reset_bit_i, host_capture_i} = 5'h00;
        {disk_capture_request_i, block_done_i, addr_step_i, ecc_pending_i} = 4'h0;
        {ecc_done_ok_i, ecc_uncorrectable_i} = 2'h0;
        ce_i = 1'b1;
        segment_size_i = 23'h00_1000;
        err_count = 0;
        n_compared = 0;
        repeat (20) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        t_regs();
        t_addr();
        t_pipe();
        t_count();
        stop_test();
    end
    initial cyc = 0;
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
endmodule : dbd_setup_tb
